// ### dtc_counter.sv
// One 16-bit up/down timer with prescaler and source selection
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_counter #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] ctrl,
	input wire logic ext_rise,
	input wire logic ext_fall,
	input wire logic latch_edge,
	input wire logic dir_level,
	input wire logic load_en,
	input wire logic [WIDTH-1:0] load_val,
	input wire logic clear,
	output logic [WIDTH-1:0] count,
	output logic wrap
);
	logic [`DTC_PRESC_BITS-1:0] presc_r;
	logic [`DTC_PRESC_BITS-1:0] presc_mask;
	logic tick;
	logic ext_tick;
	logic count_down;
	logic [WIDTH-1:0] count_r;
	dtc_pkg::dtc_mode_e mode;
	dtc_pkg::dtc_edge_e edge_sel;

	assign mode = dtc_pkg::dtc_mode_e'(ctrl[`DTC_CTL_MODE_MSB:`DTC_CTL_MODE_LSB]);
	assign edge_sel = dtc_pkg::dtc_edge_e'(ctrl[`DTC_CTL_EDGE_MSB:`DTC_CTL_EDGE_LSB]);
	// Divide by 4 at code 000b, doubling up to 512 at 111b
	assign presc_mask = (`DTC_PRESC_BITS'(1) << (4'(ctrl[`DTC_CTL_SEL_MSB:`DTC_CTL_SEL_LSB])
		+ 4'(`DTC_PRESC_BASE_SHIFT))) - `DTC_PRESC_BITS'(1); // R9
	// Pin direction level inverts the software direction when enabled
	assign count_down = ctrl[`DTC_CTL_DIR] ^ (ctrl[`DTC_CTL_DIR_PIN_EN] & dir_level); // R2

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			presc_r <= '0;
		end else if (!ctrl[`DTC_CTL_RUN]) begin
			presc_r <= '0;
		end else if ((presc_r & presc_mask) == presc_mask) begin
			presc_r <= '0;
		end else begin
			presc_r <= presc_r + `DTC_PRESC_BITS'(1);
		end
	end

	always_comb begin
		ext_tick = 1'b0;
		unique case (edge_sel)
			dtc_pkg::DTC_EDGE_NONE: ext_tick = 1'b0;
			dtc_pkg::DTC_EDGE_RISE: ext_tick = ext_rise;
			dtc_pkg::DTC_EDGE_FALL: ext_tick = ext_fall;
			dtc_pkg::DTC_EDGE_BOTH: ext_tick = ext_rise | ext_fall;
		endcase
	end

	always_comb begin
		tick = 1'b0;
		if (ctrl[`DTC_CTL_RUN]) begin
			unique case (mode)
				dtc_pkg::DTC_MODE_TIMER: tick = ((presc_r & presc_mask) == presc_mask); // R1
				dtc_pkg::DTC_MODE_EXT: tick = ext_tick; // R1
				dtc_pkg::DTC_MODE_LATCH: tick = latch_edge; // R4
				default: tick = 1'b0;
			endcase
		end
	end

	// Wraps at both 16-bit limits
	assign wrap = tick & (count_down ? (count_r == '0) : (count_r == '1)); // R10

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_r <= '0;
		end else if (load_en) begin
			count_r <= load_val;
		end else if (clear) begin
			count_r <= '0; // R7
		end else if (tick) begin
			count_r <= count_down ? count_r - WIDTH'(1) : count_r + WIDTH'(1); // R10
		end
	end

	assign count = count_r;
endmodule

// ### dtc_defs.svh
// Register offsets, field positions, reset values and counts for the dual timer block
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define DTC_OFF_AUX_CTRL 8'h00
`define DTC_OFF_CORE_CTRL 8'h04
`define DTC_OFF_AUX_CNT 8'h08
`define DTC_OFF_CORE_CNT 8'h0C
`define DTC_OFF_CAPTURE_RELOAD_REG 8'h10
`define DTC_OFF_CAP_CTRL 8'h14

// ----------------------------------------------------------------------------
// Timer control fields
// ----------------------------------------------------------------------------
`define DTC_CTL_SEL_LSB 0
`define DTC_CTL_SEL_MSB 2
`define DTC_CTL_MODE_LSB 3
`define DTC_CTL_MODE_MSB 4
`define DTC_CTL_DIR 5
`define DTC_CTL_DIR_PIN_EN 6
`define DTC_CTL_RUN 7
`define DTC_CTL_EDGE_LSB 8
`define DTC_CTL_EDGE_MSB 9
`define DTC_CTL_OUT_EN 10
`define DTC_CTL_LATCH 11
`define DTC_CTL_RELOAD_EN 12

// ----------------------------------------------------------------------------
// Capture control fields
// ----------------------------------------------------------------------------
`define DTC_CAP_SRC_LSB 0
`define DTC_CAP_SRC_MSB 1
`define DTC_CAP_EDGE_LSB 2
`define DTC_CAP_EDGE_MSB 3
`define DTC_CAP_CLEAR 4
`define DTC_CAP_FIRST_IN 5
`define DTC_CAP_FIRST_DIR 6

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define DTC_CTRL_RST 16'h0000
`define DTC_CNT_RST 16'h0000
`define DTC_CAP_RST 8'h00
`define DTC_PRESC_BITS 9
`define DTC_PRESC_BASE_SHIFT 2

`endif

// ### dtc_dual_timer.sv
// Auxiliary and core timers with toggle latch and capture/reload register
//
// Functional notes
// R1: Timers count prescaled clock or pin events
// R2: Software direction, optionally flipped by pin
// R3: Toggle latch inverts on core wrap
// R4: Latch clocks aux timer, drives pin
// R5: Core wrap pulses cc timers, reloads core
// R6: Capture pin edge copies aux timer
// R7: Optional aux clear after capture
// R8: Capture from first module core pins
// R9: Select code sets divide 4 to 512
// R10: 16-bit timers and register, wrapping
// R11: Pins synchronised and edge detected first
// R12: Core wrap pulse lasts one cycle
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_dual_timer #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic aux_count_pin,
	input wire logic core_count_pin,
	input wire logic aux_dir_pin,
	input wire logic core_dir_pin,
	input wire logic capture_pin,
	input wire logic first_core_count_pin,
	input wire logic first_core_dir_pin,
	output logic toggle_out_pin,
	output logic cc_timer_a_tick,
	output logic cc_timer_b_tick
);
	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	localparam int NPIN = 7;
	localparam int PIN_AUX_CNT = 0;
	localparam int PIN_CORE_CNT = 1;
	localparam int PIN_AUX_DIR = 2;
	localparam int PIN_CORE_DIR = 3;
	localparam int PIN_CAPTURE = 4;
	localparam int PIN_FIRST_CNT = 5;
	localparam int PIN_FIRST_DIR = 6;
	logic [15:0] aux_ctrl_r;
	logic [15:0] core_ctrl_r;
	logic [7:0] cap_ctrl_r;
	logic [WIDTH-1:0] capture_reload_r;
	logic core_toggle_latch_r;
	logic latch_prev_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic out_r;
	logic cca_r;
	logic ccb_r;
	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] lvl;
	logic [NPIN-1:0] rise;
	logic [NPIN-1:0] fall;
	logic [WIDTH-1:0] aux_timer;
	logic [WIDTH-1:0] core_timer;
	logic core_wrap;
	logic core_reload;
	logic core_load;
	logic [WIDTH-1:0] core_load_val;
	logic aux_clear;
	logic hit_aux_ctrl;
	logic hit_core_ctrl;
	logic hit_aux_cnt;
	logic hit_core_cnt;
	logic hit_capture_reload_reg;
	logic hit_cap_ctrl;
	logic latch_edge;
	logic cap_pin_evt;
	logic cap_evt;
	logic sw_aux_wr;
	logic sw_core_wr;
	logic wr;
	logic rd;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	assign pins = {first_core_dir_pin, first_core_count_pin, capture_pin,
		core_dir_pin, aux_dir_pin, core_count_pin, aux_count_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			dtc_pin_sync u_sync (
				.sys_clk(sys_clk),
				.rst(rst),
				.pin(pins[gi]),
				.level(lvl[gi]),
				.rise(rise[gi]),
				.fall(fall[gi])
			); // R11
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction

	assign hit_aux_ctrl = reg_hit(avs_address, `DTC_OFF_AUX_CTRL);
	assign hit_core_ctrl = reg_hit(avs_address, `DTC_OFF_CORE_CTRL);
	assign hit_aux_cnt = reg_hit(avs_address, `DTC_OFF_AUX_CNT);
	assign hit_core_cnt = reg_hit(avs_address, `DTC_OFF_CORE_CNT);
	assign hit_capture_reload_reg = reg_hit(avs_address, `DTC_OFF_CAPTURE_RELOAD_REG);
	assign hit_cap_ctrl = reg_hit(avs_address, `DTC_OFF_CAP_CTRL);

	// One wait cycle per access: a request is taken while wait_r is high
	assign wr = avs_write & wait_r;
	assign rd = avs_read & wait_r;
	assign sw_aux_wr = wr & hit_aux_cnt;
	assign sw_core_wr = wr & hit_core_cnt;

	// Waitrequest drops for the one cycle after a request is taken
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= ~((avs_read | avs_write) & wait_r);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aux_ctrl_r <= `DTC_CTRL_RST;
		end else if (wr && hit_aux_ctrl) begin
			aux_ctrl_r <= merge16(aux_ctrl_r, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_ctrl_r <= `DTC_CTRL_RST;
		end else if (wr && hit_core_ctrl) begin
			core_ctrl_r <= merge16(core_ctrl_r, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cap_ctrl_r <= `DTC_CAP_RST;
		end else if (wr && hit_cap_ctrl && avs_byteenable[0]) begin
			cap_ctrl_r <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_r <= '0;
		end else if (rd) begin
			unique case (avs_address)
				`DTC_OFF_AUX_CTRL: rdata_r <= {16'h0000, aux_ctrl_r};
				`DTC_OFF_CORE_CTRL: rdata_r <= {16'h0000, core_ctrl_r[15:12],
					core_toggle_latch_r, core_ctrl_r[10:0]};
				`DTC_OFF_AUX_CNT: rdata_r <= {16'h0000, aux_timer};
				`DTC_OFF_CORE_CNT: rdata_r <= {16'h0000, core_timer};
				`DTC_OFF_CAPTURE_RELOAD_REG: rdata_r <= {16'h0000, capture_reload_r};
				`DTC_OFF_CAP_CTRL: rdata_r <= {24'h00_0000, cap_ctrl_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;

	// ------------------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------------------
	// Software load of the core timer wins over a wrap reload
	assign core_reload = core_wrap & core_ctrl_r[`DTC_CTL_RELOAD_EN]; // R5
	assign core_load = sw_core_wr | core_reload; // R5
	assign core_load_val = sw_core_wr ? avs_writedata[WIDTH-1:0] : capture_reload_r; // R5
	assign aux_clear = cap_evt & cap_ctrl_r[`DTC_CAP_CLEAR]; // R7

	dtc_counter #(.WIDTH(WIDTH)) u_aux (
		.sys_clk(sys_clk),
		.rst(rst),
		.ctrl(aux_ctrl_r),
		.ext_rise(rise[PIN_AUX_CNT]),
		.ext_fall(fall[PIN_AUX_CNT]),
		.latch_edge(latch_edge), // R4
		.dir_level(lvl[PIN_AUX_DIR]), // R2
		.load_en(sw_aux_wr),
		.load_val(avs_writedata[WIDTH-1:0]),
		.clear(aux_clear), // R7
		.count(aux_timer),
		.wrap()
	);

	dtc_counter #(.WIDTH(WIDTH)) u_core (
		.sys_clk(sys_clk),
		.rst(rst),
		.ctrl(core_ctrl_r),
		.ext_rise(rise[PIN_CORE_CNT]),
		.ext_fall(fall[PIN_CORE_CNT]),
		.latch_edge(1'b0),
		.dir_level(lvl[PIN_CORE_DIR]), // R2
		.load_en(core_load), // R5
		.load_val(core_load_val), // R5
		.clear(1'b0),
		.count(core_timer),
		.wrap(core_wrap)
	);

	// ------------------------------------------------------------------------
	// Toggle latch and outputs
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_toggle_latch_r <= 1'b0;
		end else if (core_wrap) begin
			core_toggle_latch_r <= ~core_toggle_latch_r; // R3
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			latch_prev_r <= 1'b0;
		end else begin
			latch_prev_r <= core_toggle_latch_r;
		end
	end

	// Aux timer counts on either latch transition
	assign latch_edge = core_toggle_latch_r ^ latch_prev_r; // R4

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			out_r <= 1'b0;
		end else begin
			out_r <= core_toggle_latch_r & core_ctrl_r[`DTC_CTL_OUT_EN]; // R4
		end
	end

	// Both capture/compare ticks follow every core wrap
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cca_r <= 1'b0;
		end else begin
			cca_r <= core_wrap; // R5 R12
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ccb_r <= 1'b0;
		end else begin
			ccb_r <= core_wrap; // R5 R12
		end
	end

	assign toggle_out_pin = out_r;
	assign cc_timer_a_tick = cca_r;
	assign cc_timer_b_tick = ccb_r;

	// ------------------------------------------------------------------------
	// Capture
	// ------------------------------------------------------------------------
	always_comb begin
		cap_pin_evt = 1'b0;
		unique case (dtc_pkg::dtc_edge_e'(cap_ctrl_r[`DTC_CAP_EDGE_MSB:`DTC_CAP_EDGE_LSB]))
			dtc_pkg::DTC_EDGE_NONE: cap_pin_evt = 1'b0;
			dtc_pkg::DTC_EDGE_RISE: cap_pin_evt = rise[PIN_CAPTURE]; // R6
			dtc_pkg::DTC_EDGE_FALL: cap_pin_evt = fall[PIN_CAPTURE]; // R6
			dtc_pkg::DTC_EDGE_BOTH: cap_pin_evt = rise[PIN_CAPTURE] | fall[PIN_CAPTURE]; // R6
		endcase
	end

	assign cap_evt = cap_pin_evt
		| (cap_ctrl_r[`DTC_CAP_FIRST_IN] & (rise[PIN_FIRST_CNT] | fall[PIN_FIRST_CNT])) // R8
		| (cap_ctrl_r[`DTC_CAP_FIRST_DIR] & (rise[PIN_FIRST_DIR] | fall[PIN_FIRST_DIR])); // R8

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			capture_reload_r <= `DTC_CNT_RST;
		end else if (wr && hit_capture_reload_reg) begin
			capture_reload_r <= merge16(capture_reload_r, avs_writedata, avs_byteenable);
		end else if (cap_evt) begin
			capture_reload_r <= aux_timer; // R6
		end
	end
endmodule

// ### dtc_dual_timer_props.sv
// Concurrent checks on the dual timer ports
`timescale 1ns/1ps
module dtc_dual_timer_props #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic toggle_out_pin,
	input wire logic cc_timer_a_tick,
	input wire logic cc_timer_b_tick
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	ack_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("answer without request");
	req_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered next cycle");
	wait_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	idle_hold_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("answer while idle");
	data_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without read");
	unmapped_zero_a: assert property (!avs_waitrequest && avs_read && avs_address > 8'h14
		|-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
	tick_single_a: assert property (cc_timer_a_tick |=> !cc_timer_a_tick)
		else $error("wrap tick longer than one cycle");
	ticks_pair_a: assert property (cc_timer_a_tick == cc_timer_b_tick)
		else $error("wrap ticks differ");
	rst_quiet_a: assert property (@(posedge sys_clk) disable iff (1'b0)
		rst |=> avs_waitrequest && !toggle_out_pin && !cc_timer_a_tick && !cc_timer_b_tick)
		else $error("outputs active after reset");
	cover property (cc_timer_a_tick);
	cover property (toggle_out_pin);
	cover property (!avs_waitrequest && avs_write);
endmodule
bind dtc_dual_timer dtc_dual_timer_props #(.WIDTH(WIDTH)) u_props (.sys_clk(sys_clk),
	.rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.toggle_out_pin(toggle_out_pin), .cc_timer_a_tick(cc_timer_a_tick),
	.cc_timer_b_tick(cc_timer_b_tick));

// ### dtc_dual_timer_tb.sv
// Self-checking testbench for the dual timer block
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_dual_timer_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic acp, ccp, adp, cdp, cap, fcp, fdp, tog, tka, tkb;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc_cnt = 0;
	int ticks = 0;
	int ticks_b = 0;
	logic [15:0] q;
	always #25 sys_clk = ~sys_clk;
	dtc_dual_timer u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.aux_count_pin(acp), .core_count_pin(ccp), .aux_dir_pin(adp), .core_dir_pin(cdp),
		.capture_pin(cap), .first_core_count_pin(fcp), .first_core_dir_pin(fdp),
		.toggle_out_pin(tog), .cc_timer_a_tick(tka), .cc_timer_b_tick(tkb));
	dtc_pin_model u_pins (.sys_clk(sys_clk), .aux_count_pin(acp), .core_count_pin(ccp),
		.aux_dir_pin(adp), .core_dir_pin(cdp), .capture_pin(cap),
		.first_core_count_pin(fcp), .first_core_dir_pin(fdp));
	task automatic conclude();
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One bus cycle; entered and left just after a rising edge
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		q = avs_readdata[15:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000);
		chk(nm, q, e);
	endtask
	task automatic inr(input string nm, input logic [7:0] a, input int lo, input int hi);
		acc(1'b0, a, 16'h0000);
		chk(nm, {15'h0000, (q >= lo && q <= hi)}, 16'h0001);
	endtask
	task automatic cyc(input int n);
		repeat (n) begin
			@(negedge sys_clk);
			if (tka === 1'b1)
				ticks++;
			if (tkb === 1'b1)
				ticks_b++;
		end
		@(posedge sys_clk);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd("aux ctrl", `DTC_OFF_AUX_CTRL, 16'h0000);
		rd("core count", `DTC_OFF_CORE_CNT, 16'h0000);
		wr(8'h20, 16'h5A5A);
		rd("unmapped", 8'h20, 16'h0000);
		wr(`DTC_OFF_CAPTURE_RELOAD_REG, 16'hA5C3);
		rd("capture_reload_reg", `DTC_OFF_CAPTURE_RELOAD_REG, 16'hA5C3);
		for (int c = 0; c < 8; c++) begin
			wr(`DTC_OFF_CORE_CNT, 16'h0000);
			wr(`DTC_OFF_CORE_CTRL, 16'h0080 | c[15:0]);
			cyc((4 << c) * 4);
			wr(`DTC_OFF_CORE_CTRL, c[15:0]);
			inr("prescale", `DTC_OFF_CORE_CNT, 3, 6);
		end
		wr(`DTC_OFF_CAPTURE_RELOAD_REG, 16'h0100);
		wr(`DTC_OFF_CORE_CNT, 16'h0002);
		ticks = 0;
		ticks_b = 0;
		wr(`DTC_OFF_CORE_CTRL, 16'h14A0);
		cyc(30);
		wr(`DTC_OFF_CORE_CTRL, 16'h1420);
		chk("down wrap", ticks[15:0], 16'h0001);
		chk("down wrap b", ticks_b[15:0], 16'h0001);
		chk("toggle pin", {15'h0000, tog}, 16'h0001);
		inr("reload", `DTC_OFF_CORE_CNT, 16'h00F8, 16'h00FF);
		rd("latch bit", `DTC_OFF_CORE_CTRL, 16'h1C20);
		wr(`DTC_OFF_CORE_CNT, 16'hFFFE);
		ticks = 0;
		wr(`DTC_OFF_CORE_CTRL, 16'h0480);
		cyc(30);
		wr(`DTC_OFF_CORE_CTRL, 16'h0400);
		chk("up wrap", ticks[15:0], 16'h0001);
		chk("toggle back", {15'h0000, tog}, 16'h0000);
		inr("up count", `DTC_OFF_CORE_CNT, 1, 8);
		u_pins.lvl(3, 1'b1);
		wr(`DTC_OFF_CORE_CNT, 16'h0040);
		wr(`DTC_OFF_CORE_CTRL, 16'h00C0);
		cyc(40);
		wr(`DTC_OFF_CORE_CTRL, 16'h0000);
		inr("dir pin", `DTC_OFF_CORE_CNT, 16'h0030, 16'h003F);
		u_pins.lvl(3, 1'b0);
		wr(`DTC_OFF_AUX_CNT, 16'h0000);
		wr(`DTC_OFF_AUX_CTRL, 16'h0188);
		u_pins.pulse(0, 5);
		cyc(4);
		rd("ext count", `DTC_OFF_AUX_CNT, 16'h0005);
		wr(`DTC_OFF_CAP_CTRL, 16'h0014);
		u_pins.pulse(4, 1);
		cyc(4);
		rd("capture", `DTC_OFF_CAPTURE_RELOAD_REG, 16'h0005);
		rd("clear", `DTC_OFF_AUX_CNT, 16'h0000);
		wr(`DTC_OFF_CAP_CTRL, 16'h0020);
		u_pins.pulse(0, 3);
		u_pins.pulse(5, 1);
		cyc(4);
		rd("first count", `DTC_OFF_CAPTURE_RELOAD_REG, 16'h0003);
		wr(`DTC_OFF_CAP_CTRL, 16'h0040);
		u_pins.pulse(0, 2);
		u_pins.pulse(6, 1);
		cyc(4);
		rd("first dir", `DTC_OFF_CAPTURE_RELOAD_REG, 16'h0005);
		wr(`DTC_OFF_AUX_CTRL, 16'h0388);
		u_pins.pulse(0, 1);
		cyc(4);
		rd("both edges", `DTC_OFF_AUX_CNT, 16'h0007);
		wr(`DTC_OFF_AUX_CNT, 16'h0000);
		wr(`DTC_OFF_AUX_CTRL, 16'h0090);
		wr(`DTC_OFF_CAPTURE_RELOAD_REG, 16'h0003);
		wr(`DTC_OFF_CORE_CNT, 16'h0003);
		ticks = 0;
		wr(`DTC_OFF_CORE_CTRL, 16'h10A0);
		cyc(100);
		wr(`DTC_OFF_CORE_CTRL, 16'h0000);
		cyc(4);
		inr("latch clock", `DTC_OFF_AUX_CNT, 5, 7);
		conclude();
	end
endmodule

// ### dtc_pin_model.sv
// External pin source driving count, direction and capture inputs
`timescale 1ns/1ps
module dtc_pin_model (
	input wire logic sys_clk,
	output logic aux_count_pin,
	output logic core_count_pin,
	output logic aux_dir_pin,
	output logic core_dir_pin,
	output logic capture_pin,
	output logic first_core_count_pin,
	output logic first_core_dir_pin
);
	logic [6:0] p = 7'h00;
	assign {first_core_dir_pin, first_core_count_pin, capture_pin, core_dir_pin} = p[6:3];
	assign {aux_dir_pin, core_count_pin, aux_count_pin} = p[2:0];
	// Pulses wide enough to pass the two-flop synchroniser
	task pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			p[idx] <= 1'b1;
			repeat (4) @(posedge sys_clk);
			p[idx] <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
	endtask
	task lvl(input int idx, input logic v);
		@(posedge sys_clk);
		p[idx] <= v;
	endtask
endmodule

// ### dtc_pin_sync.sv
// Two-flop synchroniser with edge detection for one external pin
`timescale 1ns/1ps
module dtc_pin_sync (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign rise = sync_r & ~last_r;
	assign fall = ~sync_r & last_r;
endmodule

// ### dtc_pkg.sv
// Types shared by the dual timer block
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_MODE_TIMER,
		DTC_MODE_EXT,
		DTC_MODE_LATCH
	} dtc_mode_e;
	typedef enum logic [1:0] {
		DTC_EDGE_NONE,
		DTC_EDGE_RISE,
		DTC_EDGE_FALL,
		DTC_EDGE_BOTH
	} dtc_edge_e;
endpackage
